// file: hdl/srts_pkg.sv
// Shared constants and types for the status report and trigger sequencer.
// Assumes a single 50 MHz clock domain and a synchronous, active-high reset.
package srts_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Status sub-register layout
    localparam int          STAT_W     = 16;
    localparam int          FIELD_W    = 15;
    localparam int          NUM_STAT   = 2;
    localparam logic        SEL_QUES   = 1'b0;
    localparam logic        SEL_OPER   = 1'b1;
    localparam logic [14:0] MASK_RESET = 15'h0000;
    localparam logic [14:0] RISE_RESET = 15'h7fff;
    localparam logic [14:0] FALL_RESET = 15'h0000;
    localparam logic [14:0] LIVE_RESET = 15'h0000;
    localparam logic [15:0] RD_RESET   = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger source selection
    localparam logic SOURCE_A   = 1'b0;
    localparam logic SOURCE_BUS = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Remote command codes, in encoding order 0 to 15
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_ARM,
        CMD_ABORT,
        CMD_RESET,
        CMD_DEV_CLEAR,
        CMD_BUS_TRIGGER_MSG,
        CMD_SET_SOURCE,
        CMD_SET_AUTO_REARM,
        CMD_PRESET_FILTERS,
        CMD_WR_MASK,
        CMD_WR_RISE,
        CMD_WR_FALL,
        CMD_RD_LIVE,
        CMD_RD_LATCHED,
        CMD_RD_MASK,
        CMD_RD_FILTERS
    } srts_cmd_t;

    // Sequencer states, in encoding order 0 to 3
    typedef enum logic [1:0] {
        IDLE_STATE,
        ARMED_STATE,
        TRIGGER_WAIT_STATE,
        MEASURE_STATE
    } srts_state_t;

endpackage

// file: hdl/srts_stat_if.sv
// Carrier between the top module and one status register unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface srts_stat_if;
    import srts_pkg::*;
    logic [FIELD_W-1:0] live;
    logic [FIELD_W-1:0] wdata;
    logic               wr_mask;
    logic               wr_rise;
    logic               wr_fall;
    logic               preset;
    logic               rd_clear;
    logic [FIELD_W-1:0] latched_q;
    logic [FIELD_W-1:0] mask_q;
    logic [FIELD_W-1:0] rise_q;
    logic [FIELD_W-1:0] fall_q;
    logic               summary;

    modport ctrl (output live, wdata, wr_mask, wr_rise, wr_fall, preset, rd_clear,
                  input  latched_q, mask_q, rise_q, fall_q, summary);
    modport unit (input  live, wdata, wr_mask, wr_rise, wr_fall, preset, rd_clear,
                  output latched_q, mask_q, rise_q, fall_q, summary);
endinterface

// file: hdl/srts_stat_unit.sv
// One status register: latched bits, report mask and transition filters.
// Assumes its live input is already synchronised to the clock.
`timescale 1ns/1ns
module srts_stat_unit
    import srts_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    srts_stat_if.unit  bus
);

    logic [FIELD_W-1:0] live_prev;
    logic [FIELD_W-1:0] latched;
    logic [FIELD_W-1:0] mask;
    logic [FIELD_W-1:0] rise;
    logic [FIELD_W-1:0] fall;
    logic [FIELD_W-1:0] next_latched;
    logic [FIELD_W-1:0] next_mask;
    logic [FIELD_W-1:0] next_rise;
    logic [FIELD_W-1:0] next_fall;
    logic [FIELD_W-1:0] set_bits;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        set_bits = (rise & bus.live & ~live_prev)
                 | (fall & ~bus.live & live_prev);
        // New edges survive a clearing read
        next_latched = (bus.rd_clear ? '0 : latched) | set_bits;
        next_mask = mask;
        next_rise = rise;
        next_fall = fall;
        if (bus.preset) begin
            next_mask = MASK_RESET;
            next_rise = RISE_RESET;
            next_fall = FALL_RESET;
        end else begin
            if (bus.wr_mask) begin
                next_mask = bus.wdata;
            end
            if (bus.wr_rise) begin
                next_rise = bus.wdata;
            end
            if (bus.wr_fall) begin
                next_fall = bus.wdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            live_prev <= LIVE_RESET;
            latched   <= '0;
            mask      <= MASK_RESET;
            rise      <= RISE_RESET;
            fall      <= FALL_RESET;
        end else begin
            live_prev <= bus.live;
            latched   <= next_latched;
            mask      <= next_mask;
            rise      <= next_rise;
            fall      <= next_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign bus.latched_q = latched;
    assign bus.mask_q    = mask;
    assign bus.rise_q    = rise;
    assign bus.fall_q    = fall;
    assign bus.summary   = |(latched & mask);

endmodule // srts_stat_unit

// file: hdl/srts_top.sv
// Trigger sequencer and status reporting for a remotely controlled meter.
// Assumes a decoded command port from the remote link and pin-level inputs.
//
// Summary of operation
// - Preset reloads masks and filters to defaults
// - Power-on puts the sequencer in idle
// - Idle ignores every trigger
// - Abort, reset or device clear force idle
// - Arm from idle enters armed state
// - Armed with source_a source starts measuring
// - Armed with bus source waits for trigger
// - Trigger while waiting starts a measurement
// - Auto re-arm, source_a: restart after each completion
// - Auto re-arm, bus: wait again after completion
// - Abort under auto re-arm does not last
// - Without re-arm, finish and stop
// - Live bits track conditions, reads leave them
// - Latched bits set from filtered live changes
// - Reading latched bits clears them
// - Summary is OR of masked latched bits
// - Rise filter latches false-to-true changes
// - Fall filter latches true-to-false changes
// - Mask and filters hold fifteen writable bits
`timescale 1ns/1ns
module srts_top
    import srts_pkg::*;
(
    input  wire logic               I_MCLK,
    input  wire logic               I_RST,
    input  wire logic               I_CMD_VALID,
    input  wire logic [3:0]         I_CMD_CODE,
    input  wire logic               I_CMD_SEL,
    input  wire logic [STAT_W-1:0]  I_CMD_DATA,
    input  wire logic [FIELD_W-1:0] I_QUES_LIVE,
    input  wire logic [FIELD_W-1:0] I_OPER_LIVE,
    input  wire logic               I_MEAS_DONE,
    output logic                    O_RD_VALID,
    output logic [STAT_W-1:0]       O_RD_DATA,
    output logic                    O_MEAS_START,
    output logic                    O_MEASURING,
    output logic [1:0]              O_SEQ_STATE,
    output logic                    O_AUTO_REARM,
    output logic                    O_SOURCE,
    output logic [NUM_STAT-1:0]     O_SUMMARY
);

    srts_cmd_t          cmd;
    logic               cmd_go;
    logic [FIELD_W-1:0] live_s1 [NUM_STAT];
    logic [FIELD_W-1:0] live_s2 [NUM_STAT];
    logic [FIELD_W-1:0] live_s3 [NUM_STAT];
    logic [FIELD_W-1:0] live_q  [NUM_STAT];
    logic [FIELD_W-1:0] next_live [NUM_STAT];
    logic [FIELD_W-1:0] live_pin  [NUM_STAT];
    logic               done_s1;
    logic               done_s2;
    logic               done_s3;
    logic               done_q;
    logic               done_prev;
    logic               next_done;
    logic               done_pulse;
    logic [FIELD_W-1:0] next_s1 [NUM_STAT];
    logic [FIELD_W-1:0] next_s2 [NUM_STAT];
    logic [FIELD_W-1:0] next_s3 [NUM_STAT];
    logic               next_done_s1;
    logic               next_done_s2;
    logic               next_done_s3;

    srts_state_t        state;
    srts_state_t        next_state;
    logic               source;
    logic               next_source;
    logic               auto_rearm;
    logic               next_auto_rearm;
    logic               next_start;
    logic               force_idle;
    logic               next_measuring;

    logic               next_rd_valid;
    logic [STAT_W-1:0]  next_rd_data;
    logic [NUM_STAT-1:0] summary_w;

    logic [FIELD_W-1:0] latched_a [NUM_STAT];
    logic [FIELD_W-1:0] mask_a    [NUM_STAT];
    logic [FIELD_W-1:0] rise_a    [NUM_STAT];
    logic [FIELD_W-1:0] fall_a    [NUM_STAT];

    srts_stat_if stat_bus [NUM_STAT] ();

    ////////////////////////////////////////////////////////////////////////////
    // Command decode helpers

    function automatic logic is_cmd(input logic go, input srts_cmd_t c, input srts_cmd_t want);
        is_cmd = go && (c == want);
    endfunction

    function automatic logic [STAT_W-1:0] pad_read(input logic [FIELD_W-1:0] v);
        pad_read = {1'b0, v};
    endfunction

    // Command aimed at one status unit
    function automatic logic unit_cmd(input logic go, input srts_cmd_t c, input srts_cmd_t want,
                                      input logic sel, input logic idx);
        unit_cmd = is_cmd(go, c, want) && (sel == idx);
    endfunction

    assign cmd        = srts_cmd_t'(I_CMD_CODE);
    assign cmd_go     = I_CMD_VALID;
    assign live_pin[0] = I_QUES_LIVE;
    assign live_pin[1] = I_OPER_LIVE;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a level counts once stages two and three agree
    // Stage one is read by stage two alone
    always_comb begin
        for (int i = 0; i < NUM_STAT; i++) begin
            next_s1[i] = live_pin[i];
            next_s2[i] = live_s1[i];
            next_s3[i] = live_s2[i];
            for (int b = 0; b < FIELD_W; b++) begin
                next_live[i][b] = (live_s2[i][b] == live_s3[i][b]) ? live_s3[i][b] : live_q[i][b];
            end
        end
        next_done_s1 = I_MEAS_DONE;
        next_done_s2 = done_s1;
        next_done_s3 = done_s2;
        next_done  = (done_s2 == done_s3) ? done_s3 : done_q;
        done_pulse = done_q & ~done_prev;
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            for (int i = 0; i < NUM_STAT; i++) begin
                live_s1[i] <= LIVE_RESET;
                live_s2[i] <= LIVE_RESET;
                live_s3[i] <= LIVE_RESET;
                live_q[i]  <= LIVE_RESET;
            end
            done_s1   <= 1'b0;
            done_s2   <= 1'b0;
            done_s3   <= 1'b0;
            done_q    <= 1'b0;
            done_prev <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_STAT; i++) begin
                live_s1[i] <= next_s1[i];
                live_s2[i] <= next_s2[i];
                live_s3[i] <= next_s3[i];
                live_q[i]  <= next_live[i];
            end
            done_s1   <= next_done_s1;
            done_s2   <= next_done_s2;
            done_s3   <= next_done_s3;
            done_q    <= next_done;
            done_prev <= done_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status register units
    for (genvar g = 0; g < NUM_STAT; g++) begin : g_stat
        assign stat_bus[g].live     = live_q[g];
        assign stat_bus[g].wdata    = I_CMD_DATA[FIELD_W-1:0];
        assign stat_bus[g].wr_mask  = unit_cmd(cmd_go, cmd, CMD_WR_MASK, I_CMD_SEL, 1'(g));
        assign stat_bus[g].wr_rise  = unit_cmd(cmd_go, cmd, CMD_WR_RISE, I_CMD_SEL, 1'(g));
        assign stat_bus[g].wr_fall  = unit_cmd(cmd_go, cmd, CMD_WR_FALL, I_CMD_SEL, 1'(g));
        assign stat_bus[g].preset   = is_cmd(cmd_go, cmd, CMD_PRESET_FILTERS);
        assign stat_bus[g].rd_clear = unit_cmd(cmd_go, cmd, CMD_RD_LATCHED, I_CMD_SEL, 1'(g));
        assign latched_a[g] = stat_bus[g].latched_q;
        assign mask_a[g]    = stat_bus[g].mask_q;
        assign rise_a[g]    = stat_bus[g].rise_q;
        assign fall_a[g]    = stat_bus[g].fall_q;
        assign summary_w[g] = stat_bus[g].summary;

        srts_stat_unit u_unit (
            .i_clk (I_MCLK),
            .i_rst (I_RST),
            .bus   (stat_bus[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Query answers; filters query returns rise when data bit 0 is clear, fall when it is set
    always_comb begin
        next_rd_valid = 1'b0;
        // Data holds the last answer between queries
        next_rd_data  = O_RD_DATA;
        if (is_cmd(cmd_go, cmd, CMD_RD_LIVE)) begin
            next_rd_valid = 1'b1;
            next_rd_data  = pad_read(live_q[I_CMD_SEL]);
        end else if (is_cmd(cmd_go, cmd, CMD_RD_LATCHED)) begin
            next_rd_valid = 1'b1;
            next_rd_data  = pad_read(latched_a[I_CMD_SEL]);
        end else if (is_cmd(cmd_go, cmd, CMD_RD_MASK)) begin
            next_rd_valid = 1'b1;
            next_rd_data  = pad_read(mask_a[I_CMD_SEL]);
        end else if (is_cmd(cmd_go, cmd, CMD_RD_FILTERS)) begin
            next_rd_valid = 1'b1;
            next_rd_data  = I_CMD_DATA[0] ? pad_read(fall_a[I_CMD_SEL]) : pad_read(rise_a[I_CMD_SEL]);
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_RD_VALID <= 1'b0;
            O_RD_DATA  <= RD_RESET;
        end else begin
            O_RD_VALID <= next_rd_valid;
            O_RD_DATA  <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger sequencer
    always_comb begin
        next_state      = state;
        next_source     = source;
        next_auto_rearm = auto_rearm;
        next_start      = 1'b0;
        // Stop commands win over all others in one cycle
        force_idle      = is_cmd(cmd_go, cmd, CMD_ABORT) || is_cmd(cmd_go, cmd, CMD_RESET)
                       || is_cmd(cmd_go, cmd, CMD_DEV_CLEAR);
        if (is_cmd(cmd_go, cmd, CMD_SET_SOURCE)) begin
            next_source = I_CMD_DATA[0];
        end
        if (is_cmd(cmd_go, cmd, CMD_SET_AUTO_REARM)) begin
            next_auto_rearm = I_CMD_DATA[0];
        end
        if (is_cmd(cmd_go, cmd, CMD_RESET)) begin
            next_auto_rearm = 1'b0;
            next_source     = SOURCE_A;
        end
        if (force_idle) begin
            next_state = IDLE_STATE;
        end else begin
            case (state)
                IDLE_STATE: begin
                    // Triggers fall through unused here
                    // Re-arm leaves idle alone, so abort cannot stop it
                    if (is_cmd(cmd_go, cmd, CMD_ARM) || auto_rearm) begin
                        next_state = ARMED_STATE;
                    end
                end
                ARMED_STATE: begin
                    if (source == SOURCE_A) begin
                        next_state = MEASURE_STATE;
                        next_start = 1'b1;
                    end else begin
                        next_state = TRIGGER_WAIT_STATE;
                    end
                end
                TRIGGER_WAIT_STATE: begin
                    if (is_cmd(cmd_go, cmd, CMD_BUS_TRIGGER_MSG)) begin
                        next_state = MEASURE_STATE;
                        next_start = 1'b1;
                    end
                end
                MEASURE_STATE: begin
                    if (done_pulse) begin
                        if (!auto_rearm) begin
                            next_state = IDLE_STATE;
                        end else if (source == SOURCE_A) begin
                            // Stay here and restart at once
                            next_start = 1'b1;
                        end else begin
                            next_state = TRIGGER_WAIT_STATE;
                        end
                    end
                end
                default: begin
                    next_state = IDLE_STATE;
                end
            endcase
        end
        next_measuring = (next_state == MEASURE_STATE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and summary registers
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            state        <= IDLE_STATE;
            source       <= SOURCE_A;
            auto_rearm   <= 1'b0;
            O_MEAS_START <= 1'b0;
            O_MEASURING  <= 1'b0;
            O_SEQ_STATE  <= 2'h0;
            O_AUTO_REARM <= 1'b0;
            O_SOURCE     <= SOURCE_A;
            O_SUMMARY    <= '0;
        end else begin
            state        <= next_state;
            source       <= next_source;
            auto_rearm   <= next_auto_rearm;
            O_MEAS_START <= next_start;
            O_MEASURING  <= next_measuring;
            O_SEQ_STATE  <= next_state;
            O_AUTO_REARM <= next_auto_rearm;
            O_SOURCE     <= next_source;
            O_SUMMARY    <= summary_w;
        end
    end

endmodule // srts_top

// file: sim/srts_top_props.sv
// Concurrent checks on the command port and sequencer of srts_top.
// Assumes it is bound to srts_top and sees only that module's ports.
`timescale 1ns/1ns
module srts_top_props
    import srts_pkg::*;
(
    input wire logic               I_MCLK,
    input wire logic               I_RST,
    input wire logic               I_CMD_VALID,
    input wire logic [3:0]         I_CMD_CODE,
    input wire logic               I_CMD_SEL,
    input wire logic [STAT_W-1:0]  I_CMD_DATA,
    input wire logic [FIELD_W-1:0] I_QUES_LIVE,
    input wire logic [FIELD_W-1:0] I_OPER_LIVE,
    input wire logic               I_MEAS_DONE,
    input wire logic               O_RD_VALID,
    input wire logic [STAT_W-1:0]  O_RD_DATA,
    input wire logic               O_MEAS_START,
    input wire logic               O_MEASURING,
    input wire logic [1:0]         O_SEQ_STATE,
    input wire logic               O_AUTO_REARM,
    input wire logic               O_SOURCE,
    input wire logic [NUM_STAT-1:0] O_SUMMARY
);
    ////////////////////////////////////////////////////////////////////////////
    // Decoded commands
    logic qry, kill, arm, trig, srcw, rew;
    assign qry  = I_CMD_VALID && (I_CMD_CODE >= 4'hc);
    assign kill = I_CMD_VALID && (I_CMD_CODE == CMD_ABORT || I_CMD_CODE == CMD_RESET
                                  || I_CMD_CODE == CMD_DEV_CLEAR);
    assign arm  = I_CMD_VALID && (I_CMD_CODE == CMD_ARM);
    assign trig = I_CMD_VALID && (I_CMD_CODE == CMD_BUS_TRIGGER_MSG);
    assign srcw = I_CMD_VALID && (I_CMD_CODE == CMD_SET_SOURCE);
    assign rew  = I_CMD_VALID && (I_CMD_CODE == CMD_SET_AUTO_REARM);

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_rd_answer: assert property (1'b1 |=> O_RD_VALID == $past(qry))
        else $error("query answer strobe wrong");
    a_rd_bit15: assert property (O_RD_VALID |-> !O_RD_DATA[15])
        else $error("answer bit 15 set");
    a_reset_idle: assert property ($fell(I_RST) |-> O_SEQ_STATE == 2'h0 && !O_MEAS_START)
        else $error("not idle after reset");
    a_kill_idle: assert property (kill |=> O_SEQ_STATE == 2'h0)
        else $error("abort did not reach idle");
    a_idle_hold: assert property (O_SEQ_STATE == 2'h0 && !O_AUTO_REARM && !arm && !rew
                                  |=> O_SEQ_STATE == 2'h0 && !O_MEAS_START)
        else $error("idle left without arm");
    a_arm_idle: assert property (O_SEQ_STATE == 2'h0 && arm |=> O_SEQ_STATE == 2'h1)
        else $error("arm not taken in idle");
    a_imm_go: assert property (O_SEQ_STATE == 2'h1 && !O_SOURCE && !kill && !srcw
                               |=> O_SEQ_STATE == 2'h3 && O_MEAS_START)
        else $error("source_a source did not start");
    a_bus_wait: assert property (O_SEQ_STATE == 2'h1 && O_SOURCE && !kill && !srcw
                                 |=> O_SEQ_STATE == 2'h2)
        else $error("bus source did not wait");
    a_trig_go: assert property (O_SEQ_STATE == 2'h2 && trig |=> O_SEQ_STATE == 2'h3 ##0 O_MEAS_START)
        else $error("trigger did not start");
    a_rearm_leave: assert property (O_SEQ_STATE == 2'h0 && O_AUTO_REARM && !kill && !rew
                                    |=> O_SEQ_STATE == 2'h1)
        else $error("auto re-arm stuck in idle");
    a_start_once: assert property (O_MEAS_START |-> O_MEASURING ##1 !O_MEAS_START)
        else $error("start pulse malformed");

    c_trig: cover property (O_SEQ_STATE == 2'h2 && trig);
    c_rearm: cover property (O_SEQ_STATE == 2'h0 && O_AUTO_REARM);
    c_read: cover property (I_CMD_VALID && I_CMD_CODE == CMD_RD_LATCHED);
endmodule // srts_top_props

bind srts_top srts_top_props u_props (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CMD_VALID(I_CMD_VALID),
    .I_CMD_CODE(I_CMD_CODE), .I_CMD_SEL(I_CMD_SEL), .I_CMD_DATA(I_CMD_DATA), .I_QUES_LIVE(I_QUES_LIVE),
    .I_OPER_LIVE(I_OPER_LIVE), .I_MEAS_DONE(I_MEAS_DONE), .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA),
    .O_MEAS_START(O_MEAS_START), .O_MEASURING(O_MEASURING), .O_SEQ_STATE(O_SEQ_STATE),
    .O_AUTO_REARM(O_AUTO_REARM), .O_SOURCE(O_SOURCE), .O_SUMMARY(O_SUMMARY));

// file: sim/srts_meas_model.sv
// Measuring engine model: answers each start with a completion level.
// Assumes it is clocked by the block clock and drives on the falling edge.
`timescale 1ns/1ns
module srts_meas_model #(
    parameter int DELAY = 6,
    parameter int HOLD  = 4
) (
    input  wire logic i_clk,
    input  wire logic i_start,
    output logic      o_done
);
    int cnt;
    initial begin
        cnt = 0;
        o_done = 1'b0;
    end
    // A new start restarts the run; done held high longer than the sync needs
    always @(negedge i_clk) begin
        if (i_start === 1'b1)
            cnt = DELAY + HOLD;
        else if (cnt > 0)
            cnt = cnt - 1;
        o_done <= (cnt > 0) && (cnt <= HOLD);
    end
endmodule // srts_meas_model

// file: sim/testbench.sv
// Self-checking bench for srts_top through its command port.
// Assumes commands one per two cycles, driven on the falling edge.
`timescale 1ns/1ns
module testbench;
    import srts_pkg::*;
    logic        I_MCLK = 0, I_RST = 1, I_CMD_VALID = 0, I_CMD_SEL = 0, I_MEAS_DONE, O_RD_VALID;
    logic [3:0]  I_CMD_CODE = 4'h0;
    logic [15:0] I_CMD_DATA = 16'h0000, O_RD_DATA;
    logic [14:0] I_QUES_LIVE = 15'h0000, I_OPER_LIVE = 15'h0000;
    logic        O_MEAS_START, O_MEASURING, O_AUTO_REARM, O_SOURCE;
    logic [1:0]  O_SEQ_STATE, O_SUMMARY;
    int          err_count = 0, compares = 0, starts = 0, n0, cycles = 0, i, s;
    srts_cmd_t   kills [3] = '{CMD_ABORT, CMD_DEV_CLEAR, CMD_RESET};

    always #10 I_MCLK = ~I_MCLK;
    srts_top dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CMD_VALID(I_CMD_VALID), .I_CMD_CODE(I_CMD_CODE),
        .I_CMD_SEL(I_CMD_SEL), .I_CMD_DATA(I_CMD_DATA), .I_QUES_LIVE(I_QUES_LIVE), .I_OPER_LIVE(I_OPER_LIVE),
        .I_MEAS_DONE(I_MEAS_DONE), .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA),
        .O_MEAS_START(O_MEAS_START), .O_MEASURING(O_MEASURING), .O_SEQ_STATE(O_SEQ_STATE),
        .O_AUTO_REARM(O_AUTO_REARM), .O_SOURCE(O_SOURCE), .O_SUMMARY(O_SUMMARY));
    srts_meas_model u_meas (.i_clk(I_MCLK), .i_start(O_MEAS_START), .o_done(I_MEAS_DONE));

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic cmd(input srts_cmd_t c, input logic sl, input logic [15:0] d);
        @(negedge I_MCLK);
        I_CMD_VALID = 1'b1;
        I_CMD_CODE = c;
        I_CMD_SEL = sl;
        I_CMD_DATA = d;
        @(negedge I_MCLK);
        I_CMD_VALID = 1'b0;
    endtask
    task automatic rd(input srts_cmd_t c, input logic sl, input logic [15:0] d, input logic [15:0] e);
        cmd(c, sl, d);
        chk(O_RD_VALID === 1'b1 && O_RD_DATA === e, "read value");
    endtask
    task automatic wst(input logic [1:0] st, input int n);
        for (int k = 0; k < n && O_SEQ_STATE !== st; k++)
            @(negedge I_MCLK);
        chk(O_SEQ_STATE === st, "sequencer state");
    endtask
    task automatic live(input logic sl, input logic [14:0] v);
        if (sl)
            I_OPER_LIVE = v;
        else
            I_QUES_LIVE = v;
        repeat (8) @(negedge I_MCLK);
    endtask

    always @(negedge I_MCLK) begin
        if (O_MEAS_START === 1'b1)
            starts++;
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("[FAIL] %0t run timed out", $time);
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(negedge I_MCLK);
        I_RST = 1'b0;
        chk(O_SEQ_STATE === 2'h0 && O_AUTO_REARM === 1'b0, "power-on state");
        for (s = 0; s < 2; s++) begin
            rd(CMD_RD_MASK, s[0], 16'h0000, 16'h0000);
            rd(CMD_RD_FILTERS, s[0], 16'h0000, 16'h7fff);
            rd(CMD_RD_FILTERS, s[0], 16'h0001, 16'h0000);
            cmd(CMD_WR_MASK, s[0], 16'hffff);
            rd(CMD_RD_MASK, s[0], 16'h0000, 16'h7fff);
            live(s[0], 15'h0005);
            rd(CMD_RD_LIVE, s[0], 16'h0000, 16'h0005);
            rd(CMD_RD_LIVE, s[0], 16'h0000, 16'h0005);
            chk(O_SUMMARY[s] === 1'b1, "summary set");
            rd(CMD_RD_LATCHED, s[0], 16'h0000, 16'h0005);
            rd(CMD_RD_LATCHED, s[0], 16'h0000, 16'h0000);
            repeat (2) @(negedge I_MCLK);
            chk(O_SUMMARY[s] === 1'b0, "summary clear");
        end
        cmd(CMD_WR_RISE, 1'b0, 16'h0000);
        cmd(CMD_WR_FALL, 1'b0, 16'h0001);
        live(1'b0, 15'h0000);
        rd(CMD_RD_LATCHED, 1'b0, 16'h0000, 16'h0001);
        cmd(CMD_WR_FALL, 1'b0, 16'h0000);
        live(1'b0, 15'h0003);
        live(1'b0, 15'h0000);
        rd(CMD_RD_LATCHED, 1'b0, 16'h0000, 16'h0000);
        cmd(CMD_WR_FALL, 1'b1, 16'h0006);
        cmd(CMD_WR_RISE, 1'b1, 16'h0000);
        cmd(CMD_PRESET_FILTERS, 1'b0, 16'h0000);
        for (s = 0; s < 2; s++) begin
            rd(CMD_RD_MASK, s[0], 16'h0000, 16'h0000);
            rd(CMD_RD_FILTERS, s[0], 16'h0000, 16'h7fff);
            rd(CMD_RD_FILTERS, s[0], 16'h0001, 16'h0000);
        end
        cmd(CMD_BUS_TRIGGER_MSG, 1'b0, 16'h0000);
        repeat (3) @(negedge I_MCLK);
        chk(O_SEQ_STATE === 2'h0 && starts == 0, "trigger in idle");
        cmd(CMD_ARM, 1'b0, 16'h0000);
        wst(2'h3, 4);
        chk(O_MEASURING === 1'b1, "measuring level");
        wst(2'h0, 40);
        repeat (10) @(negedge I_MCLK);
        chk(O_SEQ_STATE === 2'h0 && starts == 1, "no automatic restart");
        cmd(CMD_SET_SOURCE, 1'b0, 16'h0001);
        cmd(CMD_ARM, 1'b0, 16'h0000);
        wst(2'h2, 4);
        cmd(CMD_BUS_TRIGGER_MSG, 1'b0, 16'h0000);
        wst(2'h3, 2);
        wst(2'h0, 40);
        for (i = 0; i < 3; i++) begin
            cmd(CMD_SET_SOURCE, 1'b0, 16'h0001);
            cmd(CMD_ARM, 1'b0, 16'h0000);
            wst(2'h2, 4);
            cmd(kills[i], 1'b0, 16'h0000);
            wst(2'h0, 2);
        end
        chk(O_SOURCE === SOURCE_A, "reset command source");
        cmd(CMD_SET_AUTO_REARM, 1'b0, 16'h0001);
        n0 = starts;
        repeat (80) @(negedge I_MCLK);
        chk(starts - n0 >= 3, "automatic restarts");
        cmd(CMD_ABORT, 1'b0, 16'h0000);
        repeat (4) @(negedge I_MCLK);
        chk(O_SEQ_STATE !== 2'h0, "abort under re-arm");
        cmd(CMD_SET_AUTO_REARM, 1'b0, 16'h0000);
        cmd(CMD_ABORT, 1'b0, 16'h0000);
        repeat (20) @(negedge I_MCLK);
        chk(O_SEQ_STATE === 2'h0, "stopped sequence");
        cmd(CMD_SET_SOURCE, 1'b0, 16'h0001);
        cmd(CMD_SET_AUTO_REARM, 1'b0, 16'h0001);
        wst(2'h2, 6);
        cmd(CMD_BUS_TRIGGER_MSG, 1'b0, 16'h0000);
        wst(2'h3, 2);
        wst(2'h2, 40);
        I_RST = 1'b1;
        repeat (2) @(negedge I_MCLK);
        I_RST = 1'b0;
        chk(O_SEQ_STATE === 2'h0 && O_AUTO_REARM === 1'b0, "second reset");
        end_of_test();
    end
endmodule // testbench
